// ==== hw/cps_pkg.sv ====
// Package for the cache performance statistics counters
package cps_pkg;
  // Register byte offsets on the Wishbone bus
  localparam logic [7:0] CTRL_OFFSET = 8'h00;
  localparam logic [7:0] HIT_OFFSET = 8'h20;
  localparam logic [7:0] MISS_OFFSET = 8'h30;
  // Field position of the counters enable in the control register
  localparam int PERF_EN_BIT = 12;
  // Reset values
  localparam logic [31:0] COUNT_RESET = 32'h00000000;
  localparam logic PERF_EN_RESET = 1'b0;
  localparam logic [31:0] READ_ZERO = 32'h00000000;

  // Bus slave phase
  typedef enum logic [0:0] {
    CPS_IDLE = 1'b0,
    CPS_ACK = 1'b1
  } cps_phase_t;

  // Lookup result strobes from the cache lookup logic
  typedef struct packed {
    logic hit;
    logic miss;
  } cps_lookup_t;

  // Whole state of the block
  typedef struct packed {
    cps_phase_t phase;
    logic perf_en;
    logic [31:0] hit_count;
    logic [31:0] miss_count;
    logic ack;
    logic [31:0] rdata;
  } cps_state_t;
endpackage

// ==== hw/cps_counters.sv ====
// Hit and miss statistics counters with a classic Wishbone register slave
`timescale 1ns/1ps

module cps_counters #(
  parameter int CW = 32
) (
  input wire logic clk_i, // System clock, 100 MHz
  input wire logic rst_i, // Synchronous reset, active high
  input wire cps_pkg::cps_lookup_t lookup_i, // Hit and miss strobes
  input wire logic wb_cyc_i, // Wishbone cycle
  input wire logic wb_stb_i, // Wishbone strobe
  input wire logic wb_we_i, // Write enable
  input wire logic [7:0] wb_adr_i, // Byte address
  input wire logic [3:0] wb_sel_i, // Byte lanes
  input wire logic [31:0] wb_dat_i, // Write data
  output logic [31:0] wb_dat_o, // Read data
  output logic wb_ack_o, // Acknowledge
  output logic perf_en_o // Counters enable level
);

  cps_pkg::cps_state_t cur;
  cps_pkg::cps_state_t nxt;
  logic req;
  logic en_write;
  logic en_rise;

  // Word decode used for read and write
  function automatic logic [1:0] reg_sel(input logic [7:0] adr);
    if (adr == cps_pkg::CTRL_OFFSET) begin
      reg_sel = 2'h1;
    end else if (adr == cps_pkg::HIT_OFFSET) begin
      reg_sel = 2'h2;
    end else if (adr == cps_pkg::MISS_OFFSET) begin
      reg_sel = 2'h3;
    end else begin
      reg_sel = 2'h0;
    end
  endfunction

  // Control register readback, only the enable bit is implemented
  function automatic logic [31:0] read_ctrl(input logic en);
    read_ctrl = cps_pkg::READ_ZERO;
    read_ctrl[cps_pkg::PERF_EN_BIT] = en;
  endfunction

  // Request seen only while idle so each access gets exactly one ack
  assign req = wb_cyc_i && wb_stb_i && (cur.phase == cps_pkg::CPS_IDLE);
  assign en_write = req && wb_we_i && wb_sel_i[1] && (reg_sel(wb_adr_i) == 2'h1);
  assign en_rise = en_write && wb_dat_i[cps_pkg::PERF_EN_BIT] && !cur.perf_en;

  // Next state
  always_comb begin
    nxt = cur;
    nxt.ack = 1'b0;
    nxt.phase = cps_pkg::CPS_IDLE;
    if (req) begin
      nxt.ack = 1'b1;
      nxt.phase = cps_pkg::CPS_ACK;
      case (reg_sel(wb_adr_i))
        2'h1: nxt.rdata = read_ctrl(cur.perf_en);
        2'h2: nxt.rdata = cur.hit_count;
        2'h3: nxt.rdata = cur.miss_count;
        default: nxt.rdata = cps_pkg::READ_ZERO;
      endcase
    end
    // Writes to the count registers are ignored: hardware owns them
    if (en_write) begin
      nxt.perf_en = wb_dat_i[cps_pkg::PERF_EN_BIT];
    end
    // Counting uses the current enable; wrap at all ones is natural
    if (cur.perf_en && lookup_i.hit) begin
      nxt.hit_count = cur.hit_count + 32'h00000001;
    end
    if (cur.perf_en && lookup_i.miss) begin
      nxt.miss_count = cur.miss_count + 32'h00000001;
    end
    // Clear on rising enable wins over a same-cycle count
    if (en_rise) begin
      nxt.hit_count = cps_pkg::COUNT_RESET;
      nxt.miss_count = cps_pkg::COUNT_RESET;
    end
    if (rst_i) begin
      nxt.phase = cps_pkg::CPS_IDLE;
      nxt.perf_en = cps_pkg::PERF_EN_RESET;
      nxt.hit_count = cps_pkg::COUNT_RESET;
      nxt.miss_count = cps_pkg::COUNT_RESET;
      nxt.ack = 1'b0;
      nxt.rdata = cps_pkg::READ_ZERO;
    end
  end

  // State register
  always_ff @(posedge clk_i) begin
    cur <= nxt;
  end

  assign wb_dat_o = cur.rdata;
  assign wb_ack_o = cur.ack;
  assign perf_en_o = cur.perf_en;

  // Checks
  hit_count_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (cur.perf_en && lookup_i.hit && !en_rise) |=> cur.hit_count == $past(cur.hit_count) + 32'h1)
    else $error("hit count did not step");
  miss_count_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (cur.perf_en && lookup_i.miss && !en_rise) |=> cur.miss_count == $past(cur.miss_count) + 32'h1)
    else $error("miss count did not step");
  hit_clear_a: assert property (@(posedge clk_i) disable iff (rst_i)
    en_rise |=> cur.hit_count == 32'h0)
    else $error("hit count not cleared");
  miss_clear_a: assert property (@(posedge clk_i) disable iff (rst_i)
    en_rise |=> cur.miss_count == 32'h0)
    else $error("miss count not cleared");
  hit_reset_a: assert property (@(posedge clk_i)
    rst_i |=> cur.hit_count == 32'h0)
    else $error("hit count reset wrong");
  miss_reset_a: assert property (@(posedge clk_i)
    rst_i |=> cur.miss_count == 32'h0)
    else $error("miss count reset wrong");
  enable_bit_a: assert property (@(posedge clk_i) disable iff (rst_i)
    en_write |=> perf_en_o == $past(wb_dat_i[cps_pkg::PERF_EN_BIT]))
    else $error("enable bit not stored");
  hold_off_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (!cur.perf_en && !en_rise) |=> $stable(cur.hit_count) && $stable(cur.miss_count))
    else $error("counter moved while disabled");
  ack_once_a: assert property (@(posedge clk_i) disable iff (rst_i)
    wb_ack_o |=> !wb_ack_o)
    else $error("ack held two cycles");
  hit_step_c: cover property (@(posedge clk_i) cur.perf_en && lookup_i.hit);
  miss_step_c: cover property (@(posedge clk_i) cur.perf_en && lookup_i.miss);
  clear_c: cover property (@(posedge clk_i) en_rise && cur.hit_count != 32'h0);
  wrap_c: cover property (@(posedge clk_i) cur.perf_en && lookup_i.hit && (&cur.hit_count));
  rearm_c: cover property (@(posedge clk_i) en_write && cur.perf_en && lookup_i.hit);

  // Further checks on the counters, the enable and the bus answer
  // Kept as one-step implications so a failure points at one edge

  // Hit count only steps by one, clears, or holds
  hit_step_a: assert property (@(posedge clk_i) disable iff (rst_i)
    1'b1
    |=> $stable(cur.hit_count) || (cur.hit_count == 32'h0)
    || (cur.hit_count == $past(cur.hit_count) + 32'h1))
    else $error("hit count moved by more than one");

  // Miss count only steps by one, clears, or holds
  miss_step_a: assert property (@(posedge clk_i) disable iff (rst_i)
    1'b1
    |=> $stable(cur.miss_count) || (cur.miss_count == 32'h0)
    || (cur.miss_count == $past(cur.miss_count) + 32'h1))
    else $error("miss count moved by more than one");

  // No hit strobe, no hit step
  hit_idle_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (cur.perf_en && !lookup_i.hit)
    |=> $stable(cur.hit_count))
    else $error("hit count stepped without a hit");

  // No miss strobe, no miss step
  miss_idle_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (cur.perf_en && !lookup_i.miss)
    |=> $stable(cur.miss_count))
    else $error("miss count stepped without a miss");

  // Only a rising enable or a wrap from all ones may clear a nonzero hit count
  hit_keep_a: assert property (@(posedge clk_i) disable iff (rst_i)
    ((cur.hit_count != 32'h0) && !en_rise && !(&cur.hit_count))
    |=> cur.hit_count != 32'h0)
    else $error("hit count cleared without a rising enable");

  // Only a rising enable or a wrap from all ones may clear a nonzero miss count
  miss_keep_a: assert property (@(posedge clk_i) disable iff (rst_i)
    ((cur.miss_count != 32'h0) && !en_rise && !(&cur.miss_count))
    |=> cur.miss_count != 32'h0)
    else $error("miss count cleared without a rising enable");

  // Rewriting a set enable must not clear, a classic driver slip
  rewrite_keep_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (en_write && cur.perf_en && (cur.hit_count != 32'h0) && !(&cur.hit_count))
    |=> cur.hit_count != 32'h0)
    else $error("hit count cleared by a repeated enable");

  // Silent wrap of the hit count
  hit_wrap_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (cur.perf_en && lookup_i.hit && (&cur.hit_count))
    |=> cur.hit_count == 32'h0)
    else $error("hit count did not wrap");

  // Silent wrap of the miss count
  miss_wrap_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (cur.perf_en && lookup_i.miss && (&cur.miss_count))
    |=> cur.miss_count == 32'h0)
    else $error("miss count did not wrap");

  // Both strobes in one cycle step both counts
  both_step_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (cur.perf_en && lookup_i.hit && lookup_i.miss)
    |=> !$stable(cur.hit_count) && !$stable(cur.miss_count))
    else $error("paired strobes not both counted");

  // Bus writes never reach the hit count
  hit_ro_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (req && wb_we_i && (reg_sel(wb_adr_i) == 2'h2) && !(cur.perf_en && lookup_i.hit))
    |=> $stable(cur.hit_count))
    else $error("hit count written by software");

  // Bus writes never reach the miss count
  miss_ro_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (req && wb_we_i && (reg_sel(wb_adr_i) == 2'h3) && !(cur.perf_en && lookup_i.miss))
    |=> $stable(cur.miss_count))
    else $error("miss count written by software");

  // Hit count read returns the value at the taking edge
  read_hit_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (req && !wb_we_i && (reg_sel(wb_adr_i) == 2'h2))
    |=> wb_dat_o == $past(cur.hit_count))
    else $error("hit count read wrong");

  // Miss count read returns the value at the taking edge
  read_miss_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (req && !wb_we_i && (reg_sel(wb_adr_i) == 2'h3))
    |=> wb_dat_o == $past(cur.miss_count))
    else $error("miss count read wrong");

  // Control read shows the enable alone, other bits zero
  read_ctrl_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (req && !wb_we_i && (reg_sel(wb_adr_i) == 2'h1))
    |=> (wb_dat_o[cps_pkg::PERF_EN_BIT] == $past(cur.perf_en))
    && (wb_dat_o[31:13] == 19'h00000) && (wb_dat_o[11:0] == 12'h000))
    else $error("control read wrong");

  // Unmapped reads answer zero
  read_gap_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (req && !wb_we_i && (reg_sel(wb_adr_i) == 2'h0))
    |=> wb_dat_o == 32'h00000000)
    else $error("unmapped read not zero");

  // Enable moves only on a control write
  en_hold_a: assert property (@(posedge clk_i) disable iff (rst_i)
    !en_write
    |=> $stable(perf_en_o))
    else $error("enable moved without a write");

  // Without the byte lane of bit 12 the enable is left alone
  en_lane_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (req && wb_we_i && (reg_sel(wb_adr_i) == 2'h1) && !wb_sel_i[1])
    |=> $stable(perf_en_o))
    else $error("enable written through a closed lane");

  // Writing one sets the enable
  en_set_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (en_write && wb_dat_i[cps_pkg::PERF_EN_BIT])
    |=> perf_en_o)
    else $error("enable not set");

  // Writing zero clears the enable
  en_clear_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (en_write && !wb_dat_i[cps_pkg::PERF_EN_BIT])
    |=> !perf_en_o)
    else $error("enable not cleared");

  // Every taken request is answered on the next edge
  ack_take_a: assert property (@(posedge clk_i) disable iff (rst_i)
    req
    |=> wb_ack_o)
    else $error("request not acknowledged");

  // No answer without a taken request
  ack_cause_a: assert property (@(posedge clk_i) disable iff (rst_i)
    !req
    |=> !wb_ack_o)
    else $error("ack without a request");

  // Read data stands until the next taken request
  data_hold_a: assert property (@(posedge clk_i) disable iff (rst_i)
    !req
    |=> $stable(wb_dat_o))
    else $error("read data changed while idle");

  // Reset drops the answer
  rst_ack_a: assert property (@(posedge clk_i)
    rst_i
    |=> !wb_ack_o)
    else $error("ack high after reset");

  // Reset disables counting
  rst_en_a: assert property (@(posedge clk_i)
    rst_i
    |=> !perf_en_o)
    else $error("enable high after reset");

  // Reset zeroes the read data
  rst_data_a: assert property (@(posedge clk_i)
    rst_i
    |=> wb_dat_o == 32'h00000000)
    else $error("read data not zero after reset");

endmodule // cps_counters

// ==== verif/cps_lookup_model.sv ====
// Lookup logic model giving hit and miss strobes
`timescale 1ns/1ps
module cps_lookup_model (
  input wire logic clk_i, // System clock
  output cps_pkg::cps_lookup_t lookup_o // Strobes
);
  initial lookup_o = '0;
  // One lookup a cycle; hits and misses overlap from the first cycle
  task automatic burst(input int h, input int m);
    for (int i = 0; i < h || i < m; i++) begin
      @(posedge clk_i);
      lookup_o <= '{hit: i < h, miss: i < m};
    end
    @(posedge clk_i);
    lookup_o <= '0;
  endtask
endmodule // cps_lookup_model

// ==== verif/cps_counters_tb.sv ====
// Self-checking testbench for the statistics counters
`timescale 1ns/1ps
module cps_counters_tb;
  logic clk_i = 1'b0, rst_i = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0, ack, en;
  logic [7:0] adr = 8'h00;
  logic [31:0] wdat = 32'h00000000, rdat, q;
  cps_pkg::cps_lookup_t lk;
  int n_errors = 0, checked = 0;
  cps_lookup_model i_cps_lookup_model (.clk_i(clk_i), .lookup_o(lk));
  cps_counters i_cps_counters (.clk_i(clk_i), .rst_i(rst_i), .lookup_i(lk), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wdat),
    .wb_dat_o(rdat), .wb_ack_o(ack), .perf_en_o(en));
  // Clock, 10 ns period
  initial begin
    forever #5 clk_i = ~clk_i;
  end
  // Compare one word
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      n_errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Classic cycle; the edge sees ack before its own updates land
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack !== 1'b1 && n < 20);
    if (n >= 20) n_errors++;
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask
  // Read both counters
  task automatic rd2(input logic [31:0] h, input logic [31:0] m);
    wb(1'b0, cps_pkg::HIT_OFFSET, 32'h00000000);
    chk(q, h);
    wb(1'b0, cps_pkg::MISS_OFFSET, 32'h00000000);
    chk(q, m);
  endtask
  task automatic stop_test();
    $display("compares %0d, mismatches %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  // Watchdog, far beyond the fewer than a hundred cycles needed
  initial begin
    #100000;
    n_errors++;
    stop_test();
  end
  // Tests
  initial begin
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    rd2(32'h00000000, 32'h00000000);
    $display("reset test done");
    wb(1'b1, cps_pkg::CTRL_OFFSET, 32'h00001000);
    chk({31'h00000000, en}, 32'h00000001);
    i_cps_lookup_model.burst(3, 2);
    rd2(32'h00000003, 32'h00000002);
    wb(1'b1, cps_pkg::HIT_OFFSET, 32'hFFFFFFFF);
    wb(1'b1, cps_pkg::CTRL_OFFSET, 32'h00001000);
    rd2(32'h00000003, 32'h00000002);
    wb(1'b1, cps_pkg::CTRL_OFFSET, 32'h00000000);
    i_cps_lookup_model.burst(2, 2);
    rd2(32'h00000003, 32'h00000002);
    $display("count test done");
    wb(1'b1, cps_pkg::CTRL_OFFSET, 32'h00001000);
    rd2(32'h00000000, 32'h00000000);
    wb(1'b0, 8'h40, 32'h00000000);
    chk(q, 32'h00000000);
    $display("clear test done");
    stop_test();
  end
endmodule // cps_counters_tb
